// ### pll_pkg.sv
// Constants shared by the frequency-synthesis control block
//
// How it works
// - Reference clock passes a programmable input divider before phase comparison.
// - Feedback comes from the primary output or an external pin or logic clock.
// - Feedback divider makes the output a multiple of the divided reference.
// - Adjustable delay on reference or feedback path, static or dynamic.
// - A dynamic delay change drops lock until the lock time elapses again.
// - Post-scaler divides the oscillator to form the primary output.
// - Secondary divider derives a slower divided output from the primary output.
// - Shifted output alters phase and duty of primary, static or dynamic.
// - Reduced variant has everything except delay adjustment; delay pins ignored.
// - Main reset high holds counters, oscillator, pump and dividers in reset.
// - Secondary-divider reset holds that divider alone, independent of main reset.
// - Lock output high when the oscillator tracks the reference, else low.
// - Delay source select high uses delay pins, low uses stored delay.
// - Delay-zero high adds no delay, low applies the 3-bit step.
// - Lead select high gives a leading adjustment, low a lagging one.
// - A 4-bit phase step applies when the phase-adjust mode input is high.
// - A 4-bit duty select sets shifted duty when phase-adjust mode is high.
`default_nettype none

package pll_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADR_DIV    = 8'h00;
  localparam logic [7:0]  ADR_ADJ    = 8'h04;
  localparam logic [7:0]  ADR_STATUS = 8'h08;

  localparam logic [31:0] DIV_RST    = 32'h02010101;
  localparam logic [31:0] ADJ_RST    = 32'h00008000;
  localparam logic [31:0] ADJ_MASK   = 32'h0001FF1F;

  // DIV fields
  localparam int DIV_REF_LSB  = 0;
  localparam int DIV_FB_LSB   = 8;
  localparam int DIV_POST_LSB = 16;
  localparam int DIV_SEC_LSB  = 24;

  // ADJ fields
  localparam int ADJ_STEP_LSB  = 0;
  localparam int ADJ_LEAD_BIT  = 3;
  localparam int ADJ_ZERO_BIT  = 4;
  localparam int ADJ_PHASE_LSB = 8;
  localparam int ADJ_DUTY_LSB  = 12;
  localparam int ADJ_FBEXT_BIT = 16;

  // STATUS fields
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_VCO_LSB  = 8;

  // ----------------------------------------------------------------
  // Loop model
  // ----------------------------------------------------------------
  localparam logic [7:0] VCO_HALF_RST = 8'h10;
  localparam logic [7:0] VCO_HALF_MIN = 8'h01;
  localparam logic [7:0] VCO_HALF_MAX = 8'hFF;
  localparam logic [2:0] BAL_MID      = 3'h2;
  localparam logic [2:0] BAL_TOP      = 3'h4;
  localparam logic [2:0] BAL_BOT      = 3'h0;
  localparam logic [3:0] SLOT_HALF    = 4'h8;

  // A divide value of zero acts as one
  function automatic logic [7:0] div_of(input logic [7:0] v);
    return (v == 8'h00) ? 8'h01 : v;
  endfunction : div_of

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

endpackage : pll_pkg

`default_nettype wire

// ### pll_delay_line.sv
// Tapped event delay line for the reference or feedback path
`default_nettype none

module pll_delay_line (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Event in, tap select, event out
  input  wire logic       ev_i,
  input  wire logic [2:0] amount_i,
  output logic            ev_o
);

  typedef struct packed {
    logic [7:0] taps;
    logic       out;
  } dly_s;

  dly_s s;
  dly_s next_s;

  // --------------------------------------------------------------
  // Tap select
  // --------------------------------------------------------------
  always_comb begin
    next_s      = s;
    next_s.taps = {s.taps[6:0], ev_i};
    next_s.out  = (amount_i == 3'h0) ? ev_i : s.taps[amount_i - 3'h1];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ev_o = s.out;

endmodule : pll_delay_line

`default_nettype wire

// ### pll_digital_control.sv
// Digital control, dividers and lock logic of the synthesizer
`default_nettype none

module pll_digital_control #(
  parameter bit FULL_SYNTH   = 1'b1,
  parameter int LOCK_TIME_NS = 100000
) (
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Clock pins
  input  wire logic        ref_clk_in_i,
  input  wire logic        feedback_clk_in_i,
  // Resets from user logic
  input  wire logic        pll_reset_i,
  input  wire logic        kdiv_reset_i,
  // Dynamic delay control
  input  wire logic        delay_ctrl_source_i,
  input  wire logic        delay_zero_i,
  input  wire logic        delay_lead_sel_i,
  input  wire logic [2:0]  delay_step_i,
  // Dynamic phase and duty control
  input  wire logic        phase_adjust_mode_i,
  input  wire logic [3:0]  phase_step_i,
  input  wire logic [3:0]  duty_select_i,
  // Clock outputs and lock
  output logic             primary_clk_out_o,
  output logic             shifted_clk_out_o,
  output logic             divided_clk_out_o,
  output logic             lock_o
);

  localparam int LOCK_CYCLES =
    (LOCK_TIME_NS + pll_pkg::CLK_PERIOD_NS - 1) / pll_pkg::CLK_PERIOD_NS;
  localparam logic [23:0] LOCK_MAX = 24'(LOCK_CYCLES);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [31:0] div;
    logic [31:0] adj;
    logic [1:0]  ref_sync;
    logic [1:0]  fb_sync;
    logic        ref_prev;
    logic        fb_prev;
    logic [7:0]  ref_cnt;
    logic [7:0]  fb_cnt;
    logic        ref_ev;
    logic        fb_ev;
    logic [2:0]  bal;
    logic [7:0]  vco_half;
    logic [7:0]  vco_cnt;
    logic        vco;
    logic [7:0]  post_cnt;
    logic [3:0]  slot;
    logic        primary;
    logic        shifted;
    logic [7:0]  sec_cnt;
    logic        divided;
    logic [3:0]  last_dly;
    logic [23:0] lock_cnt;
    logic        lock;
  } state_s;

  state_s s;
  state_s next_s;

  logic       ref_dly;
  logic       fb_dly;
  logic       dyn;
  logic       dly_zero;
  logic       dly_lead;
  logic [2:0] dly_step;
  logic [2:0] amt;
  logic [2:0] ref_amt;
  logic [2:0] fb_amt;
  logic       dly_chg;
  logic [3:0] phase;
  logic [3:0] duty;
  logic       fb_lvl;
  logic       adjust;
  logic       req;

  // ----------------------------------------------------------------
  // Delay and phase source selection
  // ----------------------------------------------------------------
  always_comb begin
    dyn      = delay_ctrl_source_i;
    dly_zero = dyn ? delay_zero_i : s.adj[pll_pkg::ADJ_ZERO_BIT];
    dly_lead = dyn ? delay_lead_sel_i : s.adj[pll_pkg::ADJ_LEAD_BIT];
    dly_step = dyn ? delay_step_i : s.adj[pll_pkg::ADJ_STEP_LSB +: 3];
    amt      = (!FULL_SYNTH || dly_zero) ? 3'h0 : dly_step;
    // Delaying feedback pulls the output earlier, delaying reference later
    fb_amt   = dly_lead ? amt : 3'h0;
    ref_amt  = dly_lead ? 3'h0 : amt;
    dly_chg  = FULL_SYNTH && dyn && ({dly_lead, amt} != s.last_dly);
    phase    = phase_adjust_mode_i ? phase_step_i
                                   : s.adj[pll_pkg::ADJ_PHASE_LSB +: 4];
    duty     = phase_adjust_mode_i ? duty_select_i
                                   : s.adj[pll_pkg::ADJ_DUTY_LSB +: 4];
  end

  // ----------------------------------------------------------------
  // Path delays
  // ----------------------------------------------------------------
  pll_delay_line u_ref_delay (
    .clk_i    (clk_i),
    .rst_i    (rst_i || pll_reset_i),
    .ev_i     (s.ref_ev),
    .amount_i (ref_amt),
    .ev_o     (ref_dly)
  );

  pll_delay_line u_fb_delay (
    .clk_i    (clk_i),
    .rst_i    (rst_i || pll_reset_i),
    .ev_i     (s.fb_ev),
    .amount_i (fb_amt),
    .ev_o     (fb_dly)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    req    = cyc_i && stb_i && !s.ack;
    adjust = 1'b0;
    fb_lvl = s.adj[pll_pkg::ADJ_FBEXT_BIT] ? s.fb_sync[1] : s.primary;

    // Bus slave: one wait state, unmapped reads give zero
    next_s.ack = req;
    if (req && we_i) begin
      unique case (adr_i)
        pll_pkg::ADR_DIV: next_s.div = pll_pkg::merge(s.div, dat_i, sel_i);
        pll_pkg::ADR_ADJ: next_s.adj = pll_pkg::merge(s.adj, dat_i, sel_i)
                                       & pll_pkg::ADJ_MASK;
        default: ;
      endcase
    end
    next_s.rdat = 32'h00000000;
    if (req && !we_i) begin
      unique case (adr_i)
        pll_pkg::ADR_DIV:    next_s.rdat = s.div;
        pll_pkg::ADR_ADJ:    next_s.rdat = s.adj;
        pll_pkg::ADR_STATUS: begin
          next_s.rdat[pll_pkg::ST_LOCK_BIT]     = s.lock;
          next_s.rdat[pll_pkg::ST_VCO_LSB +: 8] = s.vco_half;
        end
        default: ;
      endcase
    end

    // Pin synchronisers
    next_s.ref_sync = {s.ref_sync[0], ref_clk_in_i};
    next_s.fb_sync  = {s.fb_sync[0], feedback_clk_in_i};
    next_s.ref_prev = s.ref_sync[1];
    next_s.fb_prev  = fb_lvl;

    // Input divider
    next_s.ref_ev = 1'b0;
    if (s.ref_sync[1] && !s.ref_prev) begin
      if (s.ref_cnt >= pll_pkg::div_of(s.div[pll_pkg::DIV_REF_LSB +: 8]) - 8'h01) begin
        next_s.ref_cnt = 8'h00;
        next_s.ref_ev  = 1'b1;
      end else begin
        next_s.ref_cnt = s.ref_cnt + 8'h01;
      end
    end

    // Feedback divider
    next_s.fb_ev = 1'b0;
    if (fb_lvl && !s.fb_prev) begin
      if (s.fb_cnt >= pll_pkg::div_of(s.div[pll_pkg::DIV_FB_LSB +: 8]) - 8'h01) begin
        next_s.fb_cnt = 8'h00;
        next_s.fb_ev  = 1'b1;
      end else begin
        next_s.fb_cnt = s.fb_cnt + 8'h01;
      end
    end

    // Phase detector: a lead of two events steers the oscillator
    if (ref_dly && !fb_dly) begin
      next_s.bal = s.bal + 3'h1;
    end else if (fb_dly && !ref_dly) begin
      next_s.bal = s.bal - 3'h1;
    end
    if (next_s.bal == pll_pkg::BAL_TOP) begin
      adjust          = 1'b1;
      next_s.bal      = pll_pkg::BAL_MID + 3'h1;
      if (s.vco_half > pll_pkg::VCO_HALF_MIN) begin
        next_s.vco_half = s.vco_half - 8'h01;
      end
    end else if (next_s.bal == pll_pkg::BAL_BOT) begin
      adjust          = 1'b1;
      next_s.bal      = pll_pkg::BAL_MID - 3'h1;
      if (s.vco_half < pll_pkg::VCO_HALF_MAX) begin
        next_s.vco_half = s.vco_half + 8'h01;
      end
    end

    // Oscillator and post-scaler, sixteen slots per output period
    if (s.vco_cnt >= s.vco_half - 8'h01) begin
      next_s.vco_cnt = 8'h00;
      next_s.vco     = !s.vco;
      if (!s.vco) begin
        if (s.post_cnt >= pll_pkg::div_of(s.div[pll_pkg::DIV_POST_LSB +: 8]) - 8'h01) begin
          next_s.post_cnt = 8'h00;
          next_s.slot     = s.slot + 4'h1;
        end else begin
          next_s.post_cnt = s.post_cnt + 8'h01;
        end
      end
    end else begin
      next_s.vco_cnt = s.vco_cnt + 8'h01;
    end
    next_s.primary = (next_s.slot < pll_pkg::SLOT_HALF);
    next_s.shifted = ((next_s.slot - phase) < duty);

    // Secondary divider counts both edges of the primary output
    if (next_s.primary != s.primary) begin
      if (s.sec_cnt >= pll_pkg::div_of(s.div[pll_pkg::DIV_SEC_LSB +: 8]) - 8'h01) begin
        next_s.sec_cnt = 8'h00;
        next_s.divided = !s.divided;
      end else begin
        next_s.sec_cnt = s.sec_cnt + 8'h01;
      end
    end
    if (kdiv_reset_i) begin
      next_s.sec_cnt = 8'h00;
      next_s.divided = 1'b0;
    end

    // Lock timer restarts on any steering or dynamic delay change
    next_s.last_dly = {dly_lead, amt};
    if (adjust || dly_chg) begin
      next_s.lock_cnt = 24'h000000;
    end else if (s.lock_cnt < LOCK_MAX) begin
      next_s.lock_cnt = s.lock_cnt + 24'h000001;
    end

    // Main reset holds the whole loop but not the registers
    if (pll_reset_i) begin
      next_s.ref_cnt  = 8'h00;
      next_s.fb_cnt   = 8'h00;
      next_s.ref_ev   = 1'b0;
      next_s.fb_ev    = 1'b0;
      next_s.bal      = pll_pkg::BAL_MID;
      next_s.vco_half = pll_pkg::VCO_HALF_RST;
      next_s.vco_cnt  = 8'h00;
      next_s.vco      = 1'b0;
      next_s.post_cnt = 8'h00;
      next_s.slot     = 4'h0;
      next_s.primary  = 1'b0;
      next_s.shifted  = 1'b0;
      next_s.sec_cnt  = 8'h00;
      next_s.divided  = 1'b0;
      next_s.lock_cnt = 24'h000000;
    end
    next_s.lock = !pll_reset_i && (next_s.lock_cnt == LOCK_MAX);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s          <= '0;
      s.div      <= pll_pkg::DIV_RST;
      s.adj      <= pll_pkg::ADJ_RST;
      s.bal      <= pll_pkg::BAL_MID;
      s.vco_half <= pll_pkg::VCO_HALF_RST;
    end else begin
      s <= next_s;
    end
  end

  assign dat_o             = s.rdat;
  assign ack_o             = s.ack;
  assign primary_clk_out_o = s.primary;
  assign shifted_clk_out_o = s.shifted;
  assign divided_clk_out_o = s.divided;
  assign lock_o            = s.lock;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_lock_reset_low: assert property (pll_reset_i |=> !lock_o)
    else $error("lock high after main reset");
  a_core_held: assert property (pll_reset_i |=> !primary_clk_out_o && !shifted_clk_out_o)
    else $error("outputs toggle under main reset");
  a_kdiv_held: assert property (kdiv_reset_i |=> !divided_clk_out_o)
    else $error("divided output not held by its reset");
  a_lock_timer: assert property (lock_o |-> s.lock_cnt == LOCK_MAX)
    else $error("lock without full lock time");
  a_dyn_drop: assert property (dly_chg && !pll_reset_i |=> !lock_o ##1 !lock_o)
    else $error("lock kept after dynamic delay change");
  a_zero_delay: assert property (dyn && delay_zero_i && !pll_reset_i |=> ref_dly == $past(s.ref_ev))
    else $error("delay applied while zero selected");
  // With zero chosen the taps are bypassed and only the output register remains, so an event must pass in one cycle
  a_div_reset: assert property (pll_reset_i |=> !divided_clk_out_o && s.sec_cnt == 8'h00)
    else $error("secondary divider runs under main reset");
  a_reduced_fixed: assert property (!FULL_SYNTH |-> amt == 3'h0 && !dly_chg)
    else $error("reduced variant applies a delay");
  a_lag_path: assert property (!dly_lead |-> fb_amt == 3'h0 && ref_amt == amt)
    else $error("lag delay on wrong path");
  a_duty_zero: assert property (duty == 4'h0 |=> !shifted_clk_out_o)
    else $error("shifted output high with zero duty");
  a_read_idle: assert property (!ack_o |-> dat_o == 32'h00000000)
    else $error("read data shown without ack");
  a_static_src: assert property (!dyn && FULL_SYNTH && !s.adj[pll_pkg::ADJ_ZERO_BIT]
                                 |-> amt == s.adj[2:0])
    else $error("static delay not used");
  a_lead_path: assert property (dly_lead |-> ref_amt == 3'h0 && fb_amt == amt)
    else $error("lead delay on wrong path");
  a_phase_sel: assert property (phase_adjust_mode_i |-> phase == phase_step_i
                                && duty == duty_select_i)
    else $error("dynamic phase not selected");
  a_wb_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus ack not one cycle");

  c_lock_rise: cover property ($rose(lock_o));
  c_dyn_change: cover property (dly_chg);
  c_kdiv_reset: cover property (kdiv_reset_i && primary_clk_out_o);
  c_wb_write: cover property (cyc_i && stb_i && we_i && ack_o);
  // Zero delay from the pins is one way to bypass the taps at run time, besides the stored zero bit or a step of zero
  c_zero_delay: cover property (dyn && delay_zero_i && s.ref_ev);

endmodule : pll_digital_control

`default_nettype wire

// ### pll_fabric_model.sv
// Partner model: user fabric driving the clock pins and synchronising lock
`default_nettype none

module pll_fabric_model #(
  parameter int REF_HALF = 512
) (
  // System
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Lock from the synthesizer
  input  wire logic lock_i,
  // Clock pins and synchronised lock
  output logic      ref_clk_o,
  output logic      fb_clk_o,
  output logic      lock_sync_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int   cnt;
  logic meta;

  // ----------------------------------------------------------------
  // Reference clock from routing, free running like a real source
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt       <= 0;
      ref_clk_o <= 1'b0;
    end else if (cnt == REF_HALF - 1) begin
      cnt       <= 0;
      ref_clk_o <= ~ref_clk_o;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // Same wave loops back as a user feedback clock, so no steering is needed
  assign fb_clk_o = ref_clk_o;

  // ----------------------------------------------------------------
  // Lock is asynchronous to the fabric: two flops before any use
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta        <= 1'b0;
      lock_sync_o <= 1'b0;
    end else begin
      meta        <= lock_i;
      lock_sync_o <= meta;
    end
  end

endmodule : pll_fabric_model

`default_nettype wire

// ### pll_digital_control_test.sv
// Self-checking bench for the synthesizer control block
`default_nettype none

module pll_digital_control_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  localparam int LOCK_NS = 500;
  localparam int POST    = 2;
  localparam int PERIOD  = 2 * int'(pll_pkg::VCO_HALF_RST) * POST * 16;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i, phase_step_i, duty_select_i;
  logic [31:0] dat_i, dat_o, q, seed, m_div, m_adj, d;
  logic        ref_clk, fb_clk, lock_sync, pll_reset_i, kdiv_reset_i, m_lock;
  logic        delay_ctrl_source_i, delay_zero_i, delay_lead_sel_i, phase_adjust_mode_i;
  logic [2:0]  delay_step_i;
  logic        primary, shifted, divided, lock_o, lock_red;
  int          err_total, num_checks, per, hi, n, sec, duty, ones;
  int          adrs[$] = '{0, 4, 8, 12};

  pll_digital_control #(.FULL_SYNTH(1'b1), .LOCK_TIME_NS(LOCK_NS)) u_pll_digital_control (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ref_clk_in_i(ref_clk),
    .feedback_clk_in_i(fb_clk), .pll_reset_i(pll_reset_i), .kdiv_reset_i(kdiv_reset_i),
    .delay_ctrl_source_i(delay_ctrl_source_i), .delay_zero_i(delay_zero_i),
    .delay_lead_sel_i(delay_lead_sel_i), .delay_step_i(delay_step_i),
    .phase_adjust_mode_i(phase_adjust_mode_i), .phase_step_i(phase_step_i),
    .duty_select_i(duty_select_i), .primary_clk_out_o(primary), .shifted_clk_out_o(shifted),
    .divided_clk_out_o(divided), .lock_o(lock_o));

  // Reduced variant sees the same stimulus; only its lock is watched
  pll_digital_control #(.FULL_SYNTH(1'b0), .LOCK_TIME_NS(LOCK_NS)) u_pll_digital_control_red (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(), .ack_o(), .ref_clk_in_i(ref_clk),
    .feedback_clk_in_i(fb_clk), .pll_reset_i(pll_reset_i), .kdiv_reset_i(kdiv_reset_i),
    .delay_ctrl_source_i(delay_ctrl_source_i), .delay_zero_i(delay_zero_i),
    .delay_lead_sel_i(delay_lead_sel_i), .delay_step_i(delay_step_i),
    .phase_adjust_mode_i(phase_adjust_mode_i), .phase_step_i(phase_step_i),
    .duty_select_i(duty_select_i), .primary_clk_out_o(), .shifted_clk_out_o(),
    .divided_clk_out_o(), .lock_o(lock_red));

  pll_fabric_model #(.REF_HALF(PERIOD / 2)) u_pll_fabric_model (
    .clk_i(clk_i), .rst_i(rst_i), .lock_i(lock_o), .ref_clk_o(ref_clk), .fb_clk_o(fb_clk),
    .lock_sync_o(lock_sync));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00:   return m_div;
      8'h04:   return m_adj;
      8'h08:   return {16'h0000, pll_pkg::VCO_HALF_RST, 7'h00, m_lock};
      default: return 32'h00000000;
    endcase
  endfunction : exp_rd

  function automatic logic pick(input int k);
    return (k == 0) ? primary : (k == 1) ? shifted : divided;
  endfunction : pick

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk_word

  task automatic chk_num(input int got, input int exp, input string m);
    num_checks++;
    if (got != exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %0d expected %0d", $time, m, got, exp);
    end
  endtask : chk_num

  // Classic single cycle: hold everything until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= wd;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1);
    chk_num(k, 2, "bus answer latency");
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    if (w && a == 8'h00) m_div = (m_div & ~bytes(s)) | (wd & bytes(s));
    if (w && a == 8'h04) m_adj = ((m_adj & ~bytes(s)) | (wd & bytes(s))) & pll_pkg::ADJ_MASK;
  endtask : wb

  function automatic logic [31:0] bytes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : bytes

  // Period and high time of one output, between two rising samples
  task automatic measure(input int k, output int p, output int h);
    logic low;
    p = 0;
    h = 1;
    low = 1'b0;
    n = 0;
    while (pick(k) !== 1'b0 && n < 20000) begin @(posedge clk_i); n++; end
    while (pick(k) !== 1'b1 && n < 20000) begin @(posedge clk_i); n++; end
    do begin
      @(posedge clk_i);
      p++;
      if (pick(k) === 1'b0) low = 1'b1;
      else if (!low) h++;
    end while (!(low && pick(k) === 1'b1) && p < 20000);
  endtask : measure

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    err_total++;
    $display("unexpected at %0t: run did not complete", $time);
    finish_test();
  end

  initial begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    {kdiv_reset_i, delay_ctrl_source_i, delay_zero_i, delay_lead_sel_i} = '0;
    {delay_step_i, phase_adjust_mode_i, phase_step_i, duty_select_i} = '0;
    rst_i = 1'b1;
    pll_reset_i = 1'b1;
    seed = 32'hC19A;
    m_div = pll_pkg::DIV_RST;
    m_adj = pll_pkg::ADJ_RST;
    m_lock = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (adrs[i]) begin
      wb(1'b0, adrs[i][7:0], 4'hF, 32'h0, q);
      chk_word(q, exp_rd(adrs[i][7:0]), "reset read");
      chk_word(lock_o, 1'b0, "lock in reset");
    end
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      wb(1'b1, adrs[i % 4][7:0], d[3:0], rnd(), q);
      wb(1'b0, adrs[i % 4][7:0], 4'hF, 32'h0, q);
      chk_word(q, exp_rd(adrs[i % 4][7:0]), "register readback");
    end
    // Dividers of one keep reference and user feedback aligned
    sec = 1 + int'(rnd() % 3);
    wb(1'b1, 8'h00, 4'hF, {sec[7:0], 8'h02, 8'h01, 8'h01}, q);
    wb(1'b1, 8'h04, 4'hF, 32'h00010000, q);
    @(posedge clk_i);
    pll_reset_i <= 1'b0;
    n = 0;
    while (lock_o !== 1'b1 && n < 30000) begin @(posedge clk_i); n++; end
    m_lock = 1'b1;
    chk_num(int'(n >= LOCK_NS / 10), 1, "lock not before lock time");
    wb(1'b0, 8'h08, 4'hF, 32'h0, q);
    chk_word(q, exp_rd(8'h08), "status when locked");
    chk_word(lock_sync, 1'b1, "synchronised lock");
    measure(0, per, hi);
    chk_num(per, PERIOD, "primary period");
    chk_num(hi, PERIOD / 2, "primary high");
    measure(2, per, hi);
    chk_num(per, sec * PERIOD, "divided period");
    ones = 0;
    repeat (PERIOD + 8) begin @(posedge clk_i); ones += int'(shifted === 1'b1); end
    chk_num(ones, 0, "stored duty zero");
    duty = 1 + int'(rnd() % 15);
    phase_adjust_mode_i <= 1'b1;
    duty_select_i <= duty[3:0];
    phase_step_i <= 4'(rnd());
    measure(1, per, hi);
    measure(1, per, hi);
    chk_num(per, PERIOD, "shifted period");
    chk_num(hi, duty * PERIOD / 16, "shifted high");
    kdiv_reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    ones = 0;
    n = 0;
    repeat (PERIOD) begin
      @(posedge clk_i);
      ones += int'(divided !== 1'b0);
      n += int'(primary === 1'b1);
    end
    chk_num(ones, 0, "divided held");
    chk_num(n, PERIOD / 2, "primary runs on");
    kdiv_reset_i <= 1'b0;
    chk_word(lock_red, 1'b1, "reduced lock");
    delay_lead_sel_i <= 1'(rnd());
    delay_ctrl_source_i <= 1'b1;
    delay_step_i <= 3'h3;
    repeat (2) @(posedge clk_i);
    ones = 0;
    n = 0;
    repeat (LOCK_NS / 10 - 10) begin
      @(posedge clk_i);
      ones += int'(lock_o !== 1'b0);
      n += int'(lock_red !== 1'b1);
    end
    chk_num(ones, 0, "lock dropped after dynamic step");
    chk_num(n, 0, "reduced ignores delay pins");
    delay_zero_i <= 1'b1;
    repeat (PERIOD + 8) @(posedge clk_i);
    chk_word(lock_o, 1'b1, "lock back with zero delay");
    pll_reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk_word({lock_o, primary, shifted, divided}, 4'h0, "outputs in loop reset");
    m_lock = 1'b0;
    wb(1'b0, 8'h00, 4'hF, 32'h0, q);
    chk_word(q, exp_rd(8'h00), "dividers kept in loop reset");
    finish_test();
  end

endmodule : pll_digital_control_test

`default_nettype wire
